//--- hdl/dunit_mode_control.sv
// Purpose: Status mode bits of the D unit and the accumulator operation
// Assumes: one operation request per enabled cycle, answer one cycle later
// Notes: guard bits and flags follow the width and extension bits
module dunit_mode_control
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // Single status bit set and clear
    input wire logic bitCmdValid,
    input wire logic bitCmdSet,
    input wire logic [3:0] bitCmdIndex,
    // Whole status word write and readback
    input wire logic stWrValid,
    input wire logic [15:0] stWrData,
    output logic [15:0] statusOne,
    // Compatibility bit kept elsewhere
    input wire logic legacyCompatMode,
    // Operation request
    input wire logic opValid,
    input wire dunit_mode_pkg::opreq_s opReq,
    // Operation result
    output logic resValid,
    output dunit_mode_pkg::result_s result,
    // External flag pin
    output logic generalOutputFlag
);

    // Shift by a count in the given direction; returns carry above the 40-bit value
    function automatic logic [40:0] shiftAcc(
        input logic [39:0] a,
        input logic [5:0] amt,
        input logic left,
        input logic fill,
        input logic wide
    );
        logic [80:0] t;
        logic [64:0] u;
        t = '0;
        u = '0;
        if (wide && left)
        begin
            t = {41'h0, a} << amt;
            return {t[40], t[39:0]};
        end
        else if (wide)
        begin
            t = {{40{fill}}, a, 1'b0} >> amt;
            return {t[0], t[40:1]};
        end
        else if (left)
        begin
            u = {33'h0, a[31:0]} << amt;
            return {u[32], 8'h00, u[31:0]};
        end
        else
        begin
            u = {{32{fill}}, a[31:0], 1'b0} >> amt;
            return {u[0], 8'h00, u[32:1]};
        end
    endfunction

    // Status register
    logic [15:0] status_ff;
    logic [15:0] nxt_status;
    dunit_mode_pkg::mode_s mode;

    always_comb
    begin
        nxt_status = status_ff;
        if (clkEn)
        begin
            if (stWrValid)
            begin
                nxt_status = stWrData & dunit_mode_pkg::ST_WRITABLE;
            end
            if (bitCmdValid && dunit_mode_pkg::ST_WRITABLE[bitCmdIndex])
            begin
                nxt_status[bitCmdIndex] = bitCmdSet;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status_ff <= dunit_mode_pkg::ST_RESET;
        end
        else
        begin
            status_ff <= nxt_status;
        end
    end

    assign mode.wide = status_ff[dunit_mode_pkg::WIDE_BIT];
    assign mode.sat = status_ff[dunit_mode_pkg::SAT_BIT];
    assign mode.sxm = status_ff[dunit_mode_pkg::SXM_BIT];
    assign mode.legacy = legacyCompatMode;

    // Operand extension
    logic [39:0] extA;
    logic [39:0] zextA;
    logic [23:0] ext24A;
    logic [16:0] ext17A;
    logic [39:0] extB;
    logic [39:0] zextB;
    logic [23:0] ext24B;
    logic [16:0] ext17B;

    dunit_operand_extend extendA (
        .operand(opReq.opA),
        .signExtMode(mode.sxm),
        .unsignedQual(opReq.unsA),
        .ext40(extA),
        .zext40(zextA),
        .ext24(ext24A),
        .ext17(ext17A)
    );

    dunit_operand_extend extendB (
        .operand(opReq.opB),
        .signExtMode(mode.sxm),
        .unsignedQual(opReq.unsB),
        .ext40(extB),
        .zext40(zextB),
        .ext24(ext24B),
        .ext17(ext17B)
    );

    // Shared adder for add, subtract, MAC and conditional subtract
    logic signed [33:0] product;
    logic [39:0] addB;
    logic [39:0] addOp;
    logic addSub;
    logic [40:0] sum41;
    logic [32:0] sum33;
    logic addCarry;
    logic addOvf;
    logic addPos;
    logic [39:0] satValue;

    assign product = $signed(ext17A) * $signed(ext17B);

    always_comb
    begin
        addSub = 1'b0;
        addB = extA;
        unique case (opReq.op)
            dunit_mode_pkg::OP_SUB:
            begin
                addSub = 1'b1;
            end
            dunit_mode_pkg::OP_MAC:
            begin
                addB = {{6{product[33]}}, product};
            end
            dunit_mode_pkg::OP_SUBC:
            begin
                addSub = 1'b1;
                addB = extA << dunit_mode_pkg::SUBC_SHIFT;
            end
            default:
            begin
                addB = extA;
            end
        endcase
        addOp = addSub ? ~addB : addB;
        sum41 = {1'b0, opReq.acc} + {1'b0, addOp} + {40'h0, addSub};
        sum33 = {1'b0, opReq.acc[31:0]} + {1'b0, addOp[31:0]} + {32'h0, addSub};
        if (mode.wide)
        begin
            addCarry = sum41[40];
            addOvf = (opReq.acc[39] == addOp[39]) && (sum41[39] != opReq.acc[39]);
            addPos = ~opReq.acc[39];
        end
        else
        begin
            addCarry = sum33[32];
            addOvf = (opReq.acc[31] == addOp[31]) && (sum41[31] != opReq.acc[31]);
            addPos = ~opReq.acc[31];
        end
    end

    dunit_saturate saturate (
        .rawValue(sum41[39:0]),
        .overflow(addOvf),
        .positiveDir(addPos),
        .wideMode(mode.wide),
        .satEnable(mode.sat),
        .value(satValue)
    );

    // Operation result
    logic resValid_ff;
    logic nxt_resValid;
    dunit_mode_pkg::result_s res_ff;
    dunit_mode_pkg::result_s nxt_res;

    always_comb
    begin
        logic [40:0] sh;
        logic [5:0] amt;
        logic left;
        logic fill;
        logic wideShift;
        logic [15:0] hiHalf;
        logic [15:0] loHalf;
        logic [23:0] hiSum;
        sh = '0;
        amt = opReq.shift[5] ? 6'(-opReq.shift) : 6'(opReq.shift);
        left = ~opReq.shift[5];
        fill = 1'b0;
        wideShift = mode.wide | mode.legacy;
        hiHalf = '0;
        loHalf = '0;
        hiSum = '0;
        nxt_resValid = resValid_ff;
        nxt_res = res_ff;
        if (clkEn)
        begin
            nxt_resValid = opValid;
        end
        if (clkEn && opValid)
        begin
            nxt_res.carry = opReq.carryIn;
            nxt_res.overflow = 1'b0;
            unique case (opReq.op)
                dunit_mode_pkg::OP_LOAD:
                begin
                    nxt_res.value = extA;
                end
                dunit_mode_pkg::OP_ADD, dunit_mode_pkg::OP_SUB, dunit_mode_pkg::OP_MAC:
                begin
                    nxt_res.value = satValue;
                    nxt_res.carry = addCarry;
                    nxt_res.overflow = addOvf;
                end
                dunit_mode_pkg::OP_SUBC:
                begin
                    if (!sum41[39])
                    begin
                        nxt_res.value = {sum41[38:0], 1'b1};
                    end
                    else
                    begin
                        nxt_res.value = {opReq.acc[38:0], 1'b0};
                    end
                end
                dunit_mode_pkg::OP_SHIFT_SIGNED:
                begin
                    fill = mode.sxm & ~opReq.unsAcc
                           & (wideShift ? opReq.acc[39] : opReq.acc[31]);
                    sh = shiftAcc(opReq.acc, amt, left, fill, wideShift);
                    nxt_res.value = sh[39:0];
                    if (!wideShift && mode.sxm)
                    begin
                        nxt_res.value[39:32] = {8{sh[31]}};
                    end
                    nxt_res.carry = sh[40];
                end
                dunit_mode_pkg::OP_SHIFT_LOGICAL:
                begin
                    sh = shiftAcc(opReq.acc, amt, left, 1'b0, mode.wide);
                    nxt_res.value = sh[39:0];
                    nxt_res.carry = sh[40];
                end
                dunit_mode_pkg::OP_ROTATE_LEFT:
                begin
                    nxt_res.value = mode.wide ? {opReq.acc[38:0], opReq.carryIn}
                        : {8'h00, opReq.acc[30:0], opReq.carryIn};
                    nxt_res.carry = mode.wide ? opReq.acc[39] : opReq.acc[31];
                end
                dunit_mode_pkg::OP_ROTATE_RIGHT:
                begin
                    nxt_res.value = mode.wide ? {opReq.carryIn, opReq.acc[39:1]}
                        : {8'h00, opReq.carryIn, opReq.acc[31:1]};
                    nxt_res.carry = opReq.acc[0];
                end
                dunit_mode_pkg::OP_AND:
                begin
                    nxt_res.value = opReq.acc & zextA;
                end
                dunit_mode_pkg::OP_OR:
                begin
                    nxt_res.value = opReq.acc | zextA;
                end
                dunit_mode_pkg::OP_DUAL_ADD:
                begin
                    hiSum = opReq.acc[39:16] + ext24B;
                    loHalf = opReq.acc[15:0] + opReq.opA;
                    nxt_res.value = {hiSum, loHalf};
                end
                dunit_mode_pkg::OP_DUAL_SHR:
                begin
                    fill = mode.sxm & ~opReq.unsAcc;
                    hiHalf = {fill & opReq.acc[31], opReq.acc[31:17]};
                    loHalf = {fill & opReq.acc[15], opReq.acc[15:1]};
                    nxt_res.value = {{8{hiHalf[15]}}, hiHalf, loHalf};
                end
                default:
                begin
                    nxt_res.value = opReq.acc;
                end
            endcase
            nxt_res.zero = wideShift ? (nxt_res.value == 40'h00_0000_0000)
                : (nxt_res.value[31:0] == 32'h0000_0000);
            nxt_res.negative = wideShift ? nxt_res.value[dunit_mode_pkg::MSB_WIDE]
                : nxt_res.value[dunit_mode_pkg::MSB_NARROW];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            resValid_ff <= 1'b0;
            res_ff <= '0;
        end
        else
        begin
            resValid_ff <= nxt_resValid;
            res_ff <= nxt_res;
        end
    end

    assign statusOne = status_ff;
    assign generalOutputFlag = status_ff[dunit_mode_pkg::FLAG_BIT];
    assign resValid = resValid_ff;
    assign result = res_ff;

endmodule

//--- hdl/dunit_mode_pkg.sv
// Purpose: Constants and carriers for the D-unit mode control block
// Assumes: 16-bit status word, 40-bit accumulators
// Notes: What this block does is listed below
package dunit_mode_pkg;

    localparam int FLAG_BIT = 13;
    localparam int WIDE_BIT = 10;
    localparam int SAT_BIT = 9;
    localparam int SXM_BIT = 8;
    localparam logic [15:0] ST_RESET = 16'h2100;
    localparam logic [15:0] ST_WRITABLE = 16'h2700;

    localparam int MSB_WIDE = 39;
    localparam int MSB_NARROW = 31;
    localparam int SUBC_SHIFT = 15;

    localparam logic [39:0] SAT40_POS = 40'h7F_FFFF_FFFF;
    localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
    localparam logic [39:0] SAT32_POS = 40'h00_7FFF_FFFF;
    localparam logic [39:0] SAT32_NEG = 40'hFF_8000_0000;

    typedef enum logic [3:0] {
        OP_LOAD = 4'h0,
        OP_ADD = 4'h1,
        OP_SUB = 4'h2,
        OP_MAC = 4'h3,
        OP_SUBC = 4'h4,
        OP_SHIFT_SIGNED = 4'h5,
        OP_SHIFT_LOGICAL = 4'h6,
        OP_ROTATE_LEFT = 4'h7,
        OP_ROTATE_RIGHT = 4'h8,
        OP_AND = 4'h9,
        OP_OR = 4'hA,
        OP_DUAL_ADD = 4'hB,
        OP_DUAL_SHR = 4'hC
    } aluop_e;

    typedef struct packed {
        logic wide;
        logic sat;
        logic sxm;
        logic legacy;
    } mode_s;

    typedef struct packed {
        aluop_e op;
        logic [39:0] acc;
        logic [15:0] opA;
        logic [15:0] opB;
        logic signed [5:0] shift;
        logic unsA;
        logic unsB;
        logic unsAcc;
        logic carryIn;
    } opreq_s;

    typedef struct packed {
        logic [39:0] value;
        logic carry;
        logic overflow;
        logic zero;
        logic negative;
    } result_s;

endpackage

//--- hdl/dunit_operand_extend.sv
// Purpose: Extend a short operand to the widths the D unit uses
// Assumes: purely combinational
// Notes: MAC form ignores the sign-extension mode
module dunit_operand_extend
(
    // Operand and qualifiers
    input wire logic [15:0] operand,
    input wire logic signExtMode,
    input wire logic unsignedQual,
    // Extended forms
    output logic [39:0] ext40,
    output logic [39:0] zext40,
    output logic [23:0] ext24,
    output logic [16:0] ext17
);
    logic fill;

    assign fill = signExtMode & ~unsignedQual & operand[15];
    assign ext40 = {{24{fill}}, operand};
    assign zext40 = {24'h00_0000, operand};
    assign ext24 = {{8{fill}}, operand};
    assign ext17 = {operand[15] & ~unsignedQual, operand};

endmodule

//--- hdl/dunit_saturate.sv
// Purpose: Replace an overflowing result with the width's limit
// Assumes: overflow and direction computed at the active sign position
// Notes: passes the raw value when saturation is off
module dunit_saturate
(
    // Raw result
    input wire logic [39:0] rawValue,
    input wire logic overflow,
    input wire logic positiveDir,
    // Mode
    input wire logic wideMode,
    input wire logic satEnable,
    // Saturated result
    output logic [39:0] value
);
    always_comb
    begin
        value = rawValue;
        if (satEnable && overflow)
        begin
            if (wideMode)
            begin
                value = positiveDir ? dunit_mode_pkg::SAT40_POS
                                    : dunit_mode_pkg::SAT40_NEG;
            end
            else
            begin
                value = positiveDir ? dunit_mode_pkg::SAT32_POS
                                    : dunit_mode_pkg::SAT32_NEG;
            end
        end
    end

endmodule

//--- tb/dunit_mode_control_checker.sv
// Purpose: Port-level checks of the D-unit mode control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to the design from the bench top file
module dunit_mode_control_checker
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // Status access
    input wire logic bitCmdValid,
    input wire logic bitCmdSet,
    input wire logic [3:0] bitCmdIndex,
    input wire logic stWrValid,
    input wire logic [15:0] stWrData,
    input wire logic [15:0] statusOne,
    // Operation
    input wire logic legacyCompatMode,
    input wire logic opValid,
    input wire dunit_mode_pkg::opreq_s opReq,
    input wire logic resValid,
    input wire dunit_mode_pkg::result_s result,
    input wire logic generalOutputFlag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    logic take;
    logic addSub;
    logic wideEff;
    logic sxm;
    assign take = clkEn && opValid;
    assign addSub = opReq.op inside {dunit_mode_pkg::OP_ADD, dunit_mode_pkg::OP_SUB};
    assign wideEff = statusOne[10] || legacyCompatMode;
    assign sxm = statusOne[8];

    AST_RESET_WORD: assert property (
        !$past(nrst) |-> statusOne == 16'h2100 && generalOutputFlag && !resValid)
        else $error("status word not at its reset value");
    AST_FLAG_FOLLOWS: assert property (
        clkEn && bitCmdValid && bitCmdIndex == 4'hD |=> generalOutputFlag == $past(bitCmdSet))
        else $error("flag pin does not follow its bit command");
    AST_WIDE_BIT: assert property (
        clkEn && bitCmdValid && bitCmdIndex == 4'hA |=> statusOne[10] == $past(bitCmdSet))
        else $error("wide mode bit does not follow its bit command");
    AST_SPARE_BITS: assert property (
        (statusOne & 16'hD8FF) == 16'h0000)
        else $error("status bits outside the mode bits are set");
    AST_SAT_WIDE: assert property (
        take && statusOne[10] && statusOne[9] && addSub
        |=> !result.overflow || result.value inside {40'h7FFFFFFFFF, 40'h8000000000})
        else $error("wide overflow not saturated to the 40-bit limits");
    AST_SAT_NARROW: assert property (
        take && !statusOne[10] && statusOne[9] && addSub
        |=> !result.overflow || result.value inside {40'h007FFFFFFF, 40'hFF80000000})
        else $error("narrow overflow not saturated to the 32-bit limits");
    AST_SIGN_BIT: assert property (
        resValid && $past(take)
        |-> result.negative == ($past(wideEff) ? result.value[39] : result.value[31]))
        else $error("negative flag taken from the wrong bit");
    AST_ZERO_SPAN: assert property (
        resValid && $past(take) |-> result.zero ==
        ($past(wideEff) ? result.value == 40'h0 : result.value[31:0] == 32'h0))
        else $error("zero flag over the wrong span");
    AST_GUARD_CLEAR: assert property (
        take && !statusOne[10] && opReq.op inside {dunit_mode_pkg::OP_SHIFT_LOGICAL,
        dunit_mode_pkg::OP_ROTATE_LEFT, dunit_mode_pkg::OP_ROTATE_RIGHT}
        |=> result.value[39:32] == 8'h00)
        else $error("guard bits not cleared by narrow rotate or logical shift");
    AST_GUARD_SIGNED: assert property (
        take && !wideEff && opReq.op == dunit_mode_pkg::OP_SHIFT_SIGNED
        |=> result.value[39:32] == ($past(sxm) ? {8{result.value[31]}} : 8'h00))
        else $error("guard bits of narrow signed shift wrong");
endmodule

//--- tb/dunit_mode_control_tb_top.sv
// Purpose: Self-checking bench for the D-unit mode control block
// Assumes: answer one cycle after an accepted request
// Notes: op codes passed as 4-bit values and cast to the op enum
module dunit_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic bitCmdValid = 1'b0;
    logic bitCmdSet = 1'b0;
    logic [3:0] bitCmdIndex = 4'h0;
    logic stWrValid = 1'b0;
    logic [15:0] stWrData = 16'h0000;
    logic legacyCompatMode = 1'b0;
    logic opValid = 1'b0;
    dunit_mode_pkg::opreq_s opReq = '0;
    logic [15:0] statusOne;
    logic resValid;
    dunit_mode_pkg::result_s result;
    logic generalOutputFlag;
    int n_errors = 0;
    int n_tests = 0;

    always #20 sys_clk = ~sys_clk;

    dunit_mode_control u_dut
    (
        .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .bitCmdValid(bitCmdValid),
        .bitCmdSet(bitCmdSet), .bitCmdIndex(bitCmdIndex), .stWrValid(stWrValid),
        .stWrData(stWrData), .statusOne(statusOne), .legacyCompatMode(legacyCompatMode),
        .opValid(opValid), .opReq(opReq), .resValid(resValid), .result(result),
        .generalOutputFlag(generalOutputFlag)
    );

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic fl(input logic got, input logic exp);
        check({39'h0, got}, {39'h0, exp});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bitcmd(input logic s, input logic [3:0] i);
        @(posedge sys_clk);
        bitCmdValid <= 1'b1;
        bitCmdSet <= s;
        bitCmdIndex <= i;
        @(posedge sys_clk);
        bitCmdValid <= 1'b0;
        #1;
    endtask
    task automatic wrword(input logic [15:0] d);
        @(posedge sys_clk);
        stWrValid <= 1'b1;
        stWrData <= d;
        @(posedge sys_clk);
        stWrValid <= 1'b0;
        #1;
    endtask
    // Flag kept set; wide, saturate, sign-extend bits as given
    task automatic mode(input logic w, input logic s, input logic x);
        wrword({2'b00, 1'b1, 2'b00, w, s, x, 8'h00});
    endtask
    task automatic op(input logic [3:0] o, input logic [39:0] acc, input logic [15:0] a,
        input logic [39:0] ev, input logic [15:0] b = 16'h0000,
        input logic [5:0] sh = 6'h00, input logic [2:0] u = 3'h0, input logic ci = 1'b0);
        @(posedge sys_clk);
        opValid <= 1'b1;
        opReq <= dunit_mode_pkg::opreq_s'{dunit_mode_pkg::aluop_e'(o), acc, a, b, sh,
            u[2], u[1], u[0], ci};
        @(posedge sys_clk);
        opValid <= 1'b0;
        #1;
        fl(resValid, 1'b1);
        check(result.value, ev);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        check(40'(statusOne), 40'h2100);
        fl(generalOutputFlag, 1'b1);
        fl(resValid, 1'b0);
        $display("reset test done");
        bitcmd(1'b1, 4'h9);
        check(40'(statusOne), 40'h2300);
        bitcmd(1'b1, 4'hA);
        check(40'(statusOne), 40'h2700);
        bitcmd(1'b1, 4'h3);
        check(40'(statusOne), 40'h2700);
        bitcmd(1'b0, 4'hD);
        fl(generalOutputFlag, 1'b0);
        bitcmd(1'b0, 4'h8);
        check(40'(statusOne), 40'h0600);
        wrword(16'hFFFF);
        check(40'(statusOne), 40'h2700);
        fl(generalOutputFlag, 1'b1);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        bitcmd(1'b0, 4'hA);
        check(40'(statusOne), 40'h2700);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        nrst <= 1'b0;
        @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        check(40'(statusOne), 40'h2100);
        $display("status test done");
        mode(1'b0, 1'b1, 1'b1);
        op(4'h1, 40'h007FFFFFFF, 16'h0001, 40'h007FFFFFFF);
        fl(result.overflow, 1'b1);
        op(4'h2, 40'hFF80000000, 16'h0001, 40'hFF80000000);
        mode(1'b0, 1'b0, 1'b1);
        op(4'h1, 40'h007FFFFFFF, 16'h0001, 40'h0080000000);
        fl(result.overflow, 1'b1);
        fl(result.negative, 1'b1);
        op(4'h1, 40'h00FFFFFFFF, 16'h0001, 40'h0100000000);
        fl(result.carry, 1'b1);
        fl(result.zero, 1'b1);
        mode(1'b1, 1'b0, 1'b1);
        op(4'h1, 40'h7FFFFFFFFF, 16'h0001, 40'h8000000000);
        fl(result.overflow, 1'b1);
        fl(result.negative, 1'b1);
        op(4'h1, 40'h00FFFFFFFF, 16'h0001, 40'h0100000000);
        fl(result.carry, 1'b0);
        fl(result.zero, 1'b0);
        mode(1'b1, 1'b1, 1'b1);
        op(4'h1, 40'h7FFFFFFFFF, 16'h0001, 40'h7FFFFFFFFF);
        op(4'h2, 40'h8000000000, 16'h0001, 40'h8000000000);
        $display("saturation test done");
        mode(1'b1, 1'b0, 1'b1);
        op(4'h0, 40'h0, 16'h8000, 40'hFFFFFF8000);
        op(4'h0, 40'h0, 16'h8000, 40'h0000008000, 16'h0000, 6'h00, 3'h4);
        op(4'h9, 40'hFFFFFFFFFF, 16'h8000, 40'h0000008000);
        op(4'hA, 40'h0100000000, 16'h8000, 40'h0100008000);
        op(4'h6, 40'h8000000000, 16'h0000, 40'h0800000000, 16'h0000, 6'h3C);
        op(4'h3, 40'h0, 16'hFFFF, 40'hFFFFFFFFFE, 16'h0002);
        op(4'hB, 40'h0, 16'h0001, 40'hFF80000001, 16'h8000);
        op(4'hC, 40'h0080008000, 16'h0000, 40'hFFC000C000);
        op(4'h4, 40'h0040000000, 16'h8000, 40'h0100000001);
        op(4'h5, 40'h8000000000, 16'h0000, 40'hF800000000, 16'h0000, 6'h3C);
        op(4'h5, 40'h4000000000, 16'h0000, 40'h0, 16'h0000, 6'h02);
        fl(result.carry, 1'b1);
        fl(result.zero, 1'b1);
        op(4'h8, 40'h1, 16'h0000, 40'h8000000000, 16'h0000, 6'h00, 3'h0, 1'b1);
        fl(result.carry, 1'b1);
        mode(1'b1, 1'b0, 1'b0);
        op(4'h0, 40'h0, 16'h8000, 40'h0000008000);
        op(4'h3, 40'h0, 16'hFFFF, 40'hFFFFFFFFFE, 16'h0002);
        op(4'hB, 40'h0, 16'h0001, 40'h0080000001, 16'h8000);
        op(4'h4, 40'h0040000000, 16'h8000, 40'h0000000001);
        op(4'h5, 40'h8000000000, 16'h0000, 40'h0800000000, 16'h0000, 6'h3C);
        $display("extension test done");
        mode(1'b0, 1'b0, 1'b1);
        op(4'h5, 40'h0080000000, 16'h0000, 40'hFFF8000000, 16'h0000, 6'h3C);
        op(4'h5, 40'h0080000000, 16'h0000, 40'h0008000000, 16'h0000, 6'h3C, 3'h1);
        op(4'h6, 40'hFF00000001, 16'h0000, 40'h0000000002, 16'h0000, 6'h01);
        op(4'h7, 40'hAB80000000, 16'h0000, 40'h1, 16'h0000, 6'h00, 3'h0, 1'b1);
        fl(result.carry, 1'b1);
        @(posedge sys_clk);
        legacyCompatMode <= 1'b1;
        op(4'h5, 40'h8000000000, 16'h0000, 40'hF800000000, 16'h0000, 6'h3C);
        fl(result.negative, 1'b1);
        op(4'h1, 40'h1200000000, 16'h0000, 40'h1200000000);
        fl(result.zero, 1'b0);
        @(posedge sys_clk);
        legacyCompatMode <= 1'b0;
        op(4'h1, 40'h1200000000, 16'h0000, 40'h1200000000);
        fl(result.zero, 1'b1);
        mode(1'b0, 1'b0, 1'b0);
        op(4'h5, 40'h0080000000, 16'h0000, 40'h0008000000, 16'h0000, 6'h3C);
        $display("shift test done");
        tally_and_finish();
    end
endmodule

bind dunit_mode_control dunit_mode_control_checker u_chk
(
    .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .bitCmdValid(bitCmdValid),
    .bitCmdSet(bitCmdSet), .bitCmdIndex(bitCmdIndex), .stWrValid(stWrValid),
    .stWrData(stWrData), .statusOne(statusOne), .legacyCompatMode(legacyCompatMode),
    .opValid(opValid), .opReq(opReq), .resValid(resValid), .result(result),
    .generalOutputFlag(generalOutputFlag)
);
